//--- rtl/cpu_status_and_privilege.sv
/*
 Processor status word, integration configuration word and the privilege and address-space
 checks for on-chip control registers.
 Assumes the execution unit drives the flag and status ports on CORE_CLK_IN, and that software
 reaches the registers over the plain register port with read data one cycle after the strobe.
*/
`timescale 1ns/10ps
// Behaviour
// R1: Status word: low condition byte, high system byte.
// R2: User reaches condition byte only; supervisor all.
// R3: Trace select: off, flow, every, reserved.
// R4: Privilege bit zero user, one supervisor.
// R5: Three-bit mask level gates interrupt requests.
// R6: Extend flag copies carry when asked.
// R7: Negative flag follows result top bit.
// R8: Zero flag set for all-zero result.
// R9: Overflow flag follows two's complement overflow.
// R10: Carry flag records carry or borrow.
// R11: Control block 4K at map-bit selected base.
// R12: Supervisor-only registers need supervisor privilege.
// R13: Selectable registers configurable per privilege.
// R14: Gate bit zero opens selectable to user.
// R15: Map bit writable once; others always.
// R16: Refused user access errors, contents unchanged.
module cpu_status_and_privilege
    import cpu_status_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic                   CORE_CLK_IN,
    input  wire logic                   SRST_IN,
    input  wire logic [`REG_ADDR_W-1:0] REG_ADDR_IN,
    input  wire logic [15:0]            REG_WDATA_IN,
    input  wire logic                   REG_WR_IN,
    input  wire logic                   REG_RD_IN,
    output logic      [15:0]            REG_RDATA_OUT,
    output logic                        REG_ERR_OUT,
    input  wire logic [WIDTH-1:0]       FLAG_RESULT_IN,
    input  wire logic                   FLAG_CARRY_IN,
    input  wire logic                   FLAG_OVF_IN,
    input  wire logic [4:0]             FLAG_UPD_IN,
    input  wire logic                   FLAG_X_FROM_C_IN,
    input  wire logic                   EXEC_PSW_WR_IN,
    input  wire logic [15:0]            EXEC_PSW_IN,
    input  wire logic [2:0]             IRQ_LEVEL_IN,
    output logic                        IRQ_TAKE_OUT,
    input  wire logic                   SPACE_VALID_IN,
    input  wire logic [23:0]            SPACE_ADDR_IN,
    input  wire logic                   SPACE_SELECTABLE_IN,
    output logic                        SPACE_HIT_OUT,
    output logic                        SPACE_FAULT_OUT,
    output logic                        SUPERVISOR_OUT,
    output logic      [2:0]             MASK_LEVEL_OUT,
    output logic                        TRACE_FLOW_OUT,
    output logic                        TRACE_EVERY_OUT,
    output logic      [15:0]            PSW_OUT
);

    generate
        if (WIDTH < 8 || WIDTH > 32) begin : g_width_check
            $error("WIDTH must lie between 8 and 32.");
        end
    endgenerate

    state_t      cur;
    state_t      next_cur;
    logic [4:0]  next_cond;
    logic        supervisor;
    trace_mode_t trace_mode;
    logic [23:0] space_base;
    logic        sel_psw;
    logic        sel_cfg;
    logic        cfg_refused;

    flag_unit #(
        .WIDTH (WIDTH)
    ) u_flags (
        .result_in       (FLAG_RESULT_IN),
        .carry_in        (FLAG_CARRY_IN),
        .overflow_in     (FLAG_OVF_IN),
        .update_in       (FLAG_UPD_IN),
        .x_from_carry_in (FLAG_X_FROM_C_IN),
        .cond_in         (cur.psw[`PSW_COND_HI:`PSW_COND_LO]),
        .cond_out        (next_cond)
    );

    assign supervisor = cur.psw[`PSW_PRIV_BIT]; // R4
    assign trace_mode = trace_mode_t'(cur.psw[`PSW_TRACE_HI:`PSW_TRACE_LO]);
    assign sel_psw    = (REG_ADDR_IN == `REG_PSW_OFFSET);
    assign sel_cfg    = (REG_ADDR_IN == `REG_CFG_OFFSET);
    assign cfg_refused = sel_cfg && !supervisor; // R12

    always_comb begin
        next_cur = cur;
        next_cur.fault = 1'b0;
        next_cur.rdata = 16'h0000;
        next_cur.psw[`PSW_COND_HI:`PSW_COND_LO] = next_cond;
        if (EXEC_PSW_WR_IN) begin
            next_cur.psw = EXEC_PSW_IN & `PSW_WRITE_MASK; // R1
        end
        if (REG_WR_IN) begin
            if (sel_psw) begin
                if (supervisor) begin
                    next_cur.psw = REG_WDATA_IN & `PSW_WRITE_MASK; // R2
                end else begin
                    next_cur.psw = (cur.psw & ~`PSW_USER_MASK) | (REG_WDATA_IN & `PSW_USER_MASK); // R2
                end
            end else if (sel_cfg) begin
                if (cfg_refused) begin
                    next_cur.fault = 1'b1; // R16
                end else begin
                    next_cur.cfg = (REG_WDATA_IN & `CFG_WRITE_MASK);
                    next_cur.map_written = 1'b1;
                    if (cur.map_written) begin
                        next_cur.cfg[`CFG_MAP_BIT] = cur.cfg[`CFG_MAP_BIT]; // R15
                    end
                end
            end
        end
        if (REG_RD_IN) begin
            if (sel_psw) begin
                next_cur.rdata = supervisor ? cur.psw : (cur.psw & `PSW_USER_MASK); // R2
            end else if (sel_cfg) begin
                if (cfg_refused) begin
                    next_cur.fault = 1'b1; // R16
                end else begin
                    next_cur.rdata = cur.cfg;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            cur.psw         <= `PSW_RESET;
            cur.cfg         <= `CFG_RESET;
            cur.map_written <= 1'b0;
            cur.rdata       <= 16'h0000;
            cur.fault       <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // Interrupt acceptance: level seven is never masked.
    assign IRQ_TAKE_OUT = (IRQ_LEVEL_IN == `IRQ_LEVEL_TOP) ||
                          (IRQ_LEVEL_IN > cur.psw[`PSW_MASK_HI:`PSW_MASK_LO]); // R5

    assign space_base = cur.cfg[`CFG_MAP_BIT] ? `SPACE_BASE_SET : `SPACE_BASE_CLEAR; // R11

    always_comb begin
        SPACE_HIT_OUT   = 1'b0;
        SPACE_FAULT_OUT = 1'b0;
        if (SPACE_VALID_IN &&
            SPACE_ADDR_IN[23:`SPACE_BLOCK_W] == space_base[23:`SPACE_BLOCK_W]) begin // R11
            SPACE_HIT_OUT = 1'b1;
            if (!supervisor) begin
                if (!SPACE_SELECTABLE_IN) begin
                    SPACE_FAULT_OUT = 1'b1; // R12
                end else begin
                    SPACE_FAULT_OUT = cur.cfg[`CFG_GATE_BIT]; // R13 R14
                end
            end
        end
    end

    assign REG_RDATA_OUT   = cur.rdata;
    assign REG_ERR_OUT     = cur.fault;
    assign SUPERVISOR_OUT  = supervisor;
    assign MASK_LEVEL_OUT  = cur.psw[`PSW_MASK_HI:`PSW_MASK_LO];
    assign TRACE_FLOW_OUT  = (trace_mode == TRACE_FLOW); // R3
    assign TRACE_EVERY_OUT = (trace_mode == TRACE_EVERY); // R3
    assign PSW_OUT         = cur.psw;

endmodule

//--- rtl/cpu_status_map.svh
/*
 Offsets, field positions, reset values and address constants of the processor status block.
 Assumes it is included by its bare name from the package; the design modules use its macros without including it.
*/
`ifndef CPU_STATUS_MAP_SVH
`define CPU_STATUS_MAP_SVH

`define REG_ADDR_W          4
`define REG_PSW_OFFSET      4'h0
`define REG_CFG_OFFSET      4'h2

`define PSW_RESET           16'h2700
`define PSW_USER_MASK       16'h001f
`define PSW_WRITE_MASK      16'he71f
`define PSW_TRACE_HI        15
`define PSW_TRACE_LO        14
`define PSW_PRIV_BIT        13
`define PSW_MASK_HI         10
`define PSW_MASK_LO         8
`define PSW_COND_HI         4
`define PSW_COND_LO         0

`define CFG_RESET           16'h00cf
`define CFG_WRITE_MASK      16'hebcf
`define CFG_GATE_BIT        7
`define CFG_MAP_BIT         6

`define SPACE_BLOCK_W       12
`define SPACE_BASE_CLEAR    24'h7ff000
`define SPACE_BASE_SET      24'hfff000

`define IRQ_LEVEL_TOP       3'h7

`endif

//--- rtl/cpu_status_pkg.sv
/*
 Types of the processor status block: trace modes and the packed state record.
 Assumes the constant header is on the include path.
*/
package cpu_status_pkg;
`include "cpu_status_map.svh"

    typedef enum logic [1:0] {
        TRACE_OFF,
        TRACE_FLOW,
        TRACE_EVERY,
        TRACE_RSVD
    } trace_mode_t;

    typedef struct packed {
        logic [15:0] psw;
        logic [15:0] cfg;
        logic        map_written;
        logic [15:0] rdata;
        logic        fault;
    } state_t;

endpackage

//--- rtl/flag_unit.sv
/*
 Condition flag computation from an execution result.
 Assumes the execution unit supplies the result, carry and overflow of the same operation.
*/
`timescale 1ns/10ps
module flag_unit
    import cpu_status_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic [WIDTH-1:0] result_in,
    input  wire logic             carry_in,
    input  wire logic             overflow_in,
    input  wire logic [4:0]       update_in,
    input  wire logic             x_from_carry_in,
    input  wire logic [4:0]       cond_in,
    output logic      [4:0]       cond_out
);

    always_comb begin
        cond_out = cond_in;
        if (update_in[4]) begin
            cond_out[4] = x_from_carry_in ? carry_in : cond_in[0]; // R6
        end
        if (update_in[3]) begin
            cond_out[3] = result_in[WIDTH-1]; // R7
        end
        if (update_in[2]) begin
            cond_out[2] = (result_in == '0); // R8
        end
        if (update_in[1]) begin
            cond_out[1] = overflow_in; // R9
        end
        if (update_in[0]) begin
            cond_out[0] = carry_in; // R10
        end
    end

endmodule

//--- verification/cpu_status_monitor.sv
/* Port checker of the processor status block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module cpu_status_monitor #(
    parameter int WIDTH = 32
) (
    input wire logic             CORE_CLK_IN,
    input wire logic             SRST_IN,
    input wire logic [3:0]       REG_ADDR_IN,
    input wire logic             REG_WR_IN,
    input wire logic             REG_RD_IN,
    input wire logic [15:0]      REG_RDATA_OUT,
    input wire logic             REG_ERR_OUT,
    input wire logic [WIDTH-1:0] FLAG_RESULT_IN,
    input wire logic [4:0]       FLAG_UPD_IN,
    input wire logic             EXEC_PSW_WR_IN,
    input wire logic [2:0]       IRQ_LEVEL_IN,
    input wire logic             IRQ_TAKE_OUT,
    input wire logic             SPACE_HIT_OUT,
    input wire logic             SPACE_FAULT_OUT,
    input wire logic             SUPERVISOR_OUT,
    input wire logic [2:0]       MASK_LEVEL_OUT,
    input wire logic             TRACE_FLOW_OUT,
    input wire logic             TRACE_EVERY_OUT,
    input wire logic [15:0]      PSW_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (SRST_IN);
    priv_bit_a: assert property (SUPERVISOR_OUT == PSW_OUT[13]) else $error("privilege bit");
    mask_field_a: assert property (MASK_LEVEL_OUT == PSW_OUT[10:8]) else $error("mask field");
    irq_gate_a: assert property (IRQ_TAKE_OUT == (IRQ_LEVEL_IN == 3'h7 || IRQ_LEVEL_IN > MASK_LEVEL_OUT))
        else $error("irq");
    trace_decode_a: assert property (TRACE_EVERY_OUT == (PSW_OUT[15:14] == 2'h2)
        && TRACE_FLOW_OUT == (PSW_OUT[15:14] == 2'h1)) else $error("trace");
    user_read_a: assert property (REG_RD_IN && !SUPERVISOR_OUT && REG_ADDR_IN == 4'h0 |=> REG_RDATA_OUT[15:5] == 11'h0)
        else $error("user read");
    user_refuse_a: assert property ((REG_RD_IN || REG_WR_IN) && !SUPERVISOR_OUT && REG_ADDR_IN == 4'h2
        |=> REG_ERR_OUT && REG_RDATA_OUT == 16'h0) else $error("refusal");
    super_ok_a: assert property ((REG_RD_IN || REG_WR_IN) && SUPERVISOR_OUT |=> !REG_ERR_OUT) else $error("error");
    zero_flag_a: assert property (FLAG_UPD_IN[2] && !REG_WR_IN && !EXEC_PSW_WR_IN
        |=> PSW_OUT[2] == ($past(FLAG_RESULT_IN) == 0)) else $error("zero flag");
    neg_flag_a: assert property (FLAG_UPD_IN[3] && !REG_WR_IN && !EXEC_PSW_WR_IN
        |=> PSW_OUT[3] == $past(FLAG_RESULT_IN[WIDTH-1])) else $error("negative flag");
    fault_gate_a: assert property (SPACE_FAULT_OUT |-> SPACE_HIT_OUT && !SUPERVISOR_OUT) else $error("fault");
    cover property (REG_ERR_OUT);
    cover property (SPACE_FAULT_OUT);
    cover property (IRQ_TAKE_OUT && MASK_LEVEL_OUT != 3'h7);
endmodule

bind cpu_status_and_privilege cpu_status_monitor #(.WIDTH(WIDTH)) monitor (.CORE_CLK_IN, .SRST_IN, .REG_ADDR_IN,
    .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .REG_ERR_OUT, .FLAG_RESULT_IN, .FLAG_UPD_IN, .EXEC_PSW_WR_IN,
    .IRQ_LEVEL_IN, .IRQ_TAKE_OUT, .SPACE_HIT_OUT, .SPACE_FAULT_OUT, .SUPERVISOR_OUT, .MASK_LEVEL_OUT,
    .TRACE_FLOW_OUT, .TRACE_EVERY_OUT, .PSW_OUT);

//--- verification/testbench.sv
/* Self-checking bench of the processor status block with a register model.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/10ps
module testbench import cpu_status_pkg::*;;
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, cy = 1'b0, ov = 1'b0, ewr = 1'b0, sv = 1'b0, ss = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0, epsw = 16'h0, psw = 16'h2700, cfg = 16'h00cf, rdata, psw_o;
    logic [31:0] res = 32'h0, r;
    logic [23:0] sa = 24'h0;
    logic [4:0]  upd = 5'h0;
    logic [2:0]  irq = 3'h0, mask;
    logic        mapw = 1'b0, xc = 1'b0, err, take, hit, flt, sup, tf, te;
    integer      mismatches = 0, checked = 0, seed = 32'hbbc30db0, i;

    cpu_status_and_privilege DUT (.CORE_CLK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REG_ERR_OUT(err), .FLAG_RESULT_IN(res),
        .FLAG_CARRY_IN(cy), .FLAG_OVF_IN(ov), .FLAG_UPD_IN(upd), .FLAG_X_FROM_C_IN(xc), .EXEC_PSW_WR_IN(ewr),
        .EXEC_PSW_IN(epsw), .IRQ_LEVEL_IN(irq), .IRQ_TAKE_OUT(take), .SPACE_VALID_IN(sv), .SPACE_ADDR_IN(sa),
        .SPACE_SELECTABLE_IN(ss), .SPACE_HIT_OUT(hit), .SPACE_FAULT_OUT(flt), .SUPERVISOR_OUT(sup),
        .MASK_LEVEL_OUT(mask), .TRACE_FLOW_OUT(tf), .TRACE_EVERY_OUT(te), .PSW_OUT(psw_o));

    initial forever #2 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic outs;
        chk(psw_o, psw);
        chk({10'h0, te, tf, sup, mask},
            {10'h0, psw[15:14] == 2'h2, psw[15:14] == 2'h1, psw[13], psw[10:8]});
        chk({15'h0, take}, {15'h0, irq == 3'h7 || irq > psw[10:8]});
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        logic [15:0] exp;
        logic        e;
        e = a == 4'h2 && !psw[13];
        exp = !w && a == 4'h0 ? (psw[13] ? psw : psw & 16'h001f) : (!w && a == 4'h2 && !e ? cfg : 16'h0);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (w && a == 4'h0)
            psw = psw[13] ? d & 16'he71f : (psw & 16'hffe0) | (d & 16'h001f);
        if (w && a == 4'h2 && !e) begin
            cfg = mapw ? (d & 16'heb8f) | (cfg & 16'h0040) : d & 16'hebcf;
            mapw = 1'b1;
        end
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
        chk({15'h0, err}, {15'h0, e});
        outs;
    endtask

    task automatic flags(input logic [4:0] u);
        @(posedge clk);
        r = r[5] ? 32'h0 : $random(seed);
        res <= r;
        cy <= r[7];
        xc <= r[8];
        ov <= r[9];
        irq <= r[14:12];
        upd <= u;
        psw[4:0] = {u[4] ? (r[8] ? r[7] : psw[0]) : psw[4], u[3] ? r[31] : psw[3],
            u[2] ? r == 0 : psw[2], u[1] ? r[9] : psw[1], u[0] ? r[7] : psw[0]};
        @(posedge clk);
        upd <= 5'h0;
        #1;
        outs;
    endtask

    task automatic exec(input logic [15:0] v);
        @(posedge clk);
        ewr <= 1'b1;
        epsw <= v;
        psw = v & 16'he71f;
        @(posedge clk);
        ewr <= 1'b0;
        #1;
        outs;
    endtask

    task automatic space(input logic [23:0] a, input logic s);
        logic h;
        h = a[23:12] == {cfg[6], 11'h7ff};
        @(posedge clk);
        sv <= 1'b1;
        sa <= a;
        ss <= s;
        #1;
        chk({14'h0, hit, flt}, {14'h0, h, h && !psw[13] && (!s || cfg[7])});
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        r = 32'h0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 4; i++) space({i[0] ? 12'hfff : 12'h7ff, 12'ha5a}, i[1]);
        for (i = 0; i < 12; i++) bus(i > 5, {1'b0, i[1:0], 1'b0}, i[0] ? 16'hffff : 16'h2000);
        exec(16'h0000);
        for (i = 0; i < 6; i++) bus(i[0], {2'h0, i[1], 1'b0}, 16'hffff);
        for (i = 0; i < 4; i++) exec({i[1:0], 14'h2300});
        bus(1'b1, 4'h2, 16'h0000);
        bus(1'b0, 4'h2, 16'h0000);
        for (i = 0; i < 400; i++) begin
            r = $random(seed);
            case (r[19:18])
                2'h0: bus(r[0], {1'b0, r[2:1], 1'b0}, r[31:16]);
                2'h1: flags(r[4:0]);
                2'h2: exec(r[15:0]);
                default: space({r[5] ? r[31:20] : {cfg[6], 11'h7ff}, r[11:0]}, r[6]);
            endcase
        end
        end_of_test;
    end

    initial begin
        #100000;
        mismatches++;
        end_of_test;
    end
endmodule
